/* File: logic/tlb_core.sv */
// Texture handle resolution, 256-entry texture LUT and 64-bit block fill.
// Assumes an Avalon-MM master for registers and a memory with waitrequest.
// Overview of operation
// - Writing the texture handle fetches the real base from memory.
// - Bit 31 of the fetched word marks the texture valid.
// - Invalid entry stalls the pipeline and raises an interrupt.
// - Look-up table holds 256 entries of 32 bits.
// - Table may act as sixteen sub-tables of sixteen entries.
// - Table loads via register writes or from memory through a handle.
// - 4- or 8-bit index gives all four colour components.
// - Separate components each look up independently through the table.
// - Pixel X and Y can address the table for fill colours.
// - Fill colour is 64 bits, written as high and low halves.
// - Legacy fill write loads both halves.
// - A font mask from texture memory selects written pixels.
// - Area stipple also gates fill pixels when enabled.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module tlb_core
	import tlb_pkg::*;
(
	input  wire logic              clk,           // System clock
	input  wire logic              rst,           // Synchronous reset
	input  wire logic [7:0]        address,       // Byte address
	input  wire logic              read,          // Read request
	input  wire logic              write,         // Write request
	input  wire logic [DATA_W-1:0] writedata,     // Write data
	output logic      [DATA_W-1:0] readdata,      // Read data
	output logic                   waitrequest,   // Slave stall
	output logic                   irq,           // Interrupt level
	output logic                   memRead,       // Memory read request
	output logic      [DATA_W-1:0] memAddr,       // Memory byte address
	input  wire logic              memWaitReq,    // Memory stall
	input  wire logic [DATA_W-1:0] memReadData,   // Memory data
	output logic                   pipeStall,     // Rendering pipeline hold
	output logic      [DATA_W-1:0] textureBase,   // Texture base in use
	input  wire logic              pixValid,      // Pixel present
	input  wire logic [7:0]        pixX,          // Pixel X
	input  wire logic [7:0]        pixY,          // Pixel Y
	input  wire logic [DATA_W-1:0] texel,         // Texel or index
	input  wire logic              maskBit,       // Font mask bit
	input  wire logic              stippleBit,    // Area stipple bit
	input  wire logic              lineStart,     // New scanline pulse
	output logic      [DATA_W-1:0] pixColour,     // Looked-up colour
	output logic                   pixWrite,      // Pixel to be written
	output logic      [63:0]       fillColour     // Block fill colour
);
	tlb_state_t            state_q;
	logic [DATA_W-1:0]     lutMem [LUT_DEPTH];
	logic [CTRL_W-1:0]     ctrl_q;
	logic [DATA_W-1:0]     texHnd_q, lutHnd_q, dirBase_q, tblBase_q;
	logic [IDX_W-1:0]      lutIdx_q;
	logic [CNT_W-1:0]      cnt_q;
	logic                  fetchLut_q;
	logic [DATA_W-1:0]     rdMux;
	logic [EV_W-1:0]       events, status, mask;
	logic                  busWr, busRd, memTake, restart, hndWr, lutHndWr;
	logic [1:0]            mode;
	logic [3:0]            subSel;
	logic [IDX_W-1:0]      loadIdx, pixIdx, lineIdx;
	logic [CNT_W-1:0]      loadLen;
	logic [DATA_W-1:0]     compCol, cleanData;

	assign busWr    = write && !waitrequest;
	assign busRd    = read && waitrequest;
	assign memTake  = memRead && !memWaitReq;
	assign restart  = busWr && address == REG_CTRL && writedata[CTRL_RESTART];
	assign hndWr    = busWr && address == REG_TEX_HND;
	assign lutHndWr = busWr && address == REG_LUT_HND;
	assign mode     = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
	assign subSel   = ctrl_q[CTRL_SUB_HI:CTRL_SUB_LO];
	assign cleanData = {1'b0, memReadData[VALID_BIT-1:0]};
	assign events[EV_INVALID] = state_q == S_FETCH && memTake && !memReadData[VALID_BIT];
	assign events[EV_LUTDONE] = state_q == S_LOAD && memTake && cnt_q + CNT_ONE == loadLen;
	// Sub-table mode narrows loads and index lookups to one 16-entry slice; component and X/Y lookups use the whole table
	assign loadLen = ctrl_q[CTRL_SPLIT] ? CNT_SUB : CNT_FULL;
	assign loadIdx = ctrl_q[CTRL_SPLIT] ? {subSel, cnt_q[3:0]} : cnt_q[IDX_W-1:0];
	assign lineIdx = pixY;

	// One wait cycle, then the answer
	always_ff @(posedge clk) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= WORD_ZERO;
		end else if (busRd) begin
			readdata <= rdMux;
		end
	end

	always_comb begin
		rdMux = WORD_ZERO;
		case (address)
			REG_CTRL:      rdMux = {20'h0_0000, ctrl_q};
			REG_STATUS:    rdMux = {30'h0000_0000, status};
			REG_IRQ_MASK:  rdMux = {30'h0000_0000, mask};
			REG_TEX_HND:   rdMux = texHnd_q;
			REG_DIR_BASE:  rdMux = dirBase_q;
			REG_TEX_BASE:  rdMux = textureBase;
			REG_HND_TABLE: rdMux = tblBase_q;
			REG_FILL_HI:   rdMux = fillColour[63:32];
			REG_FILL_LO:   rdMux = fillColour[31:0];
			REG_LUT_IDX:   rdMux = {24'h00_0000, lutIdx_q};
			REG_LUT_DATA:  rdMux = lutMem[lutIdx_q];
			REG_LUT_HND:   rdMux = lutHnd_q;
			default:       rdMux = WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q    <= CTRL_RESET;
			texHnd_q  <= WORD_ZERO;
			lutHnd_q  <= WORD_ZERO;
			dirBase_q <= WORD_ZERO;
			tblBase_q <= WORD_ZERO;
		end else if (busWr) begin
			case (address)
				REG_CTRL:      ctrl_q <= writedata[CTRL_W-1:0];
				REG_TEX_HND:   texHnd_q <= writedata;
				REG_LUT_HND:   lutHnd_q <= writedata;
				REG_DIR_BASE:  dirBase_q <= writedata;
				REG_HND_TABLE: tblBase_q <= writedata;
				default:       ;
			endcase
		end
	end

	// Index auto-increments after each data access
	always_ff @(posedge clk) begin
		if (rst) begin
			lutIdx_q <= '0;
		end else if (busWr && address == REG_LUT_IDX) begin
			lutIdx_q <= writedata[IDX_W-1:0];
		end else if ((busWr || (read && !waitrequest)) && address == REG_LUT_DATA) begin
			lutIdx_q <= lutIdx_q + 1'b1;
		end
	end

	// Memory load has priority over a register write in the same cycle
	always_ff @(posedge clk) begin
		if (state_q == S_LOAD && memTake) begin
			lutMem[loadIdx] <= memReadData;
		end else if (busWr && address == REG_LUT_DATA) begin
			lutMem[lutIdx_q] <= writedata;
		end
	end

	// Handle resolution and table load sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q    <= S_IDLE;
			memRead    <= 1'b0;
			memAddr    <= WORD_ZERO;
			fetchLut_q <= 1'b0;
			cnt_q      <= '0;
			pipeStall  <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (hndWr || lutHndWr) begin
						memRead    <= 1'b1;
						memAddr    <= tblBase_q + {writedata[DATA_W-3:0], 2'b00};
						fetchLut_q <= lutHndWr;
						pipeStall  <= 1'b1;
						state_q    <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (memTake) begin
						if (!memReadData[VALID_BIT]) begin
							memRead <= 1'b0;
							state_q <= S_STALL;
						end else if (fetchLut_q) begin
							memAddr <= cleanData;
							cnt_q   <= '0;
							state_q <= S_LOAD;
						end else begin
							memRead   <= 1'b0;
							pipeStall <= 1'b0;
							state_q   <= S_IDLE;
						end
					end
				end
				S_STALL: begin
					if (restart) begin
						memRead <= 1'b1;
						state_q <= S_FETCH;
					end
				end
				S_LOAD: begin
					if (memTake) begin
						memAddr <= memAddr + WORD_STEP;
						cnt_q   <= cnt_q + CNT_ONE;
						if (cnt_q + CNT_ONE == loadLen) begin
							memRead   <= 1'b0;
							pipeStall <= 1'b0;
							state_q   <= S_IDLE;
						end
					end
				end
				default: begin
					state_q   <= S_IDLE;
					memRead   <= 1'b0;
					pipeStall <= 1'b0;
				end
			endcase
		end
	end

	// A resolved handle replaces the directly written base
	always_ff @(posedge clk) begin
		if (rst) begin
			textureBase <= WORD_ZERO;
		end else if (state_q == S_FETCH && memTake && memReadData[VALID_BIT] && !fetchLut_q) begin
			textureBase <= cleanData;
		end else if (busWr && address == REG_DIR_BASE) begin
			textureBase <= writedata;
		end
	end

	// Pixel lookups
	always_comb begin
		pixIdx = texel[IDX_W-1:0];
		if (mode == MODE_XY) begin
			pixIdx = {pixY[3:0], pixX[3:0]};
		end else if (ctrl_q[CTRL_IDX4]) begin
			pixIdx = {subSel, texel[3:0]};
		end else if (ctrl_q[CTRL_SPLIT]) begin
			pixIdx = {subSel, texel[3:0]};
		end
	end

	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : g_comp
			logic [DATA_W-1:0] ent;
			assign ent = lutMem[texel[8*c +: 8]];
			assign compCol[8*c +: 8] = ent[8*c +: 8];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			pixColour <= WORD_ZERO;
			pixWrite  <= 1'b0;
		end else begin
			pixColour <= (mode == MODE_COMP) ? compCol : lutMem[pixIdx];
			pixWrite  <= pixValid && !pipeStall
				&& (!ctrl_q[CTRL_MASK] || maskBit)
				&& (!ctrl_q[CTRL_STIPPLE] || stippleBit);
		end
	end

	// Bus writes win over a scanline refresh in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			fillColour <= 64'h0000_0000_0000_0000;
		end else if (busWr && address == REG_FILL_LEG) begin
			fillColour <= {writedata, writedata};
		end else if (busWr && address == REG_FILL_HI) begin
			fillColour[63:32] <= writedata;
		end else if (busWr && address == REG_FILL_LO) begin
			fillColour[31:0] <= writedata;
		end else if (lineStart && ctrl_q[CTRL_PATTERN]) begin
			fillColour <= {lutMem[lineIdx], lutMem[lineIdx]};
		end
	end

	tlb_irq u_irq (
		.clk      (clk),
		.rst      (rst),
		.events   (events),
		.statusWr (busWr && address == REG_STATUS),
		.maskWr   (busWr && address == REG_IRQ_MASK),
		.wrData   (writedata[EV_W-1:0]),
		.status_q (status),
		.mask_q   (mask),
		.irq_q    (irq)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_handle_fetch: assert property (state_q == S_IDLE && hndWr |=> memRead
		&& memAddr == tblBase_q + {$past(writedata[DATA_W-3:0]), 2'b00})
		else $error("handle write did not start a fetch");
	a_invalid_halt: assert property (state_q == S_FETCH && memTake
		&& !memReadData[VALID_BIT] |=> state_q == S_STALL && pipeStall && !memRead
		##1 status[EV_INVALID])
		else $error("invalid entry did not halt and flag");
	a_valid_base: assert property (state_q == S_FETCH && memTake && memReadData[VALID_BIT]
		&& !fetchLut_q |=> textureBase == {1'b0, $past(memReadData[VALID_BIT-1:0])})
		else $error("resolved base wrong");
	a_stall_holds: assert property (state_q == S_STALL && !restart |=> pipeStall)
		else $error("pipeline released without restart");
	a_restart_refetch: assert property (state_q == S_STALL && restart
		|=> state_q == S_FETCH && memRead && memAddr == $past(memAddr))
		else $error("restart did not refetch");
	a_legacy_both: assert property (busWr && address == REG_FILL_LEG
		|=> fillColour == {2{$past(writedata)}})
		else $error("legacy fill not on both halves");
	a_fill_high: assert property (busWr && address == REG_FILL_HI
		|=> fillColour[63:32] == $past(writedata) && $stable(fillColour[31:0]))
		else $error("high fill half wrong");
	a_stipple_gate: assert property (pixValid && ctrl_q[CTRL_STIPPLE] && !stippleBit
		|=> !pixWrite)
		else $error("stippled pixel written");
	a_mask_gate: assert property (pixValid && ctrl_q[CTRL_MASK] && !maskBit |=> !pixWrite)
		else $error("masked pixel written");
	a_lut_store: assert property (busWr && address == REG_LUT_DATA && state_q != S_LOAD
		|=> lutMem[$past(lutIdx_q)] == $past(writedata))
		else $error("table word not stored");

	c_invalid_restart: cover property (state_q == S_STALL ##[1:50] restart);
	c_lut_loaded: cover property (events[EV_LUTDONE]);
	c_pattern_line: cover property (lineStart && ctrl_q[CTRL_PATTERN]);
endmodule : tlb_core

/* File: logic/tlb_pkg.sv */
// Constants for the texture look-up, handle resolution and block-fill block.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package tlb_pkg;
	localparam int DATA_W    = 32;
	localparam int LUT_DEPTH = 256;
	localparam int SUB_DEPTH = 16;
	localparam int IDX_W     = 8;
	localparam int CNT_W     = 9;
	localparam int VALID_BIT = 31;
	localparam int CLK_MHZ   = 200;

	// Byte addresses of the registers
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_IRQ_MASK  = 8'h08;
	localparam logic [7:0] REG_TEX_HND   = 8'h0C;
	localparam logic [7:0] REG_DIR_BASE  = 8'h10;
	localparam logic [7:0] REG_TEX_BASE  = 8'h14;
	localparam logic [7:0] REG_HND_TABLE = 8'h18;
	localparam logic [7:0] REG_FILL_HI   = 8'h1C;
	localparam logic [7:0] REG_FILL_LO   = 8'h20;
	localparam logic [7:0] REG_FILL_LEG  = 8'h24;
	localparam logic [7:0] REG_LUT_IDX   = 8'h28;
	localparam logic [7:0] REG_LUT_DATA  = 8'h2C;
	localparam logic [7:0] REG_LUT_HND   = 8'h30;

	// Control register fields
	localparam int CTRL_SPLIT   = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_MODE_HI = 2;
	localparam int CTRL_IDX4    = 3;
	localparam int CTRL_PATTERN = 4;
	localparam int CTRL_STIPPLE = 5;
	localparam int CTRL_MASK    = 6;
	localparam int CTRL_SUB_LO  = 8;
	localparam int CTRL_SUB_HI  = 11;
	localparam int CTRL_RESTART = 12;
	localparam int CTRL_W       = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

	// Lookup modes
	localparam logic [1:0] MODE_INDEX = 2'h0;
	localparam logic [1:0] MODE_COMP  = 2'h1;
	localparam logic [1:0] MODE_XY    = 2'h2;

	// Interrupt status bits
	localparam int EV_W       = 2;
	localparam int EV_INVALID = 0;
	localparam int EV_LUTDONE = 1;

	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_STEP = 32'h0000_0004;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 9'h001;
	localparam logic [CNT_W-1:0]  CNT_FULL  = 9'h100;
	localparam logic [CNT_W-1:0]  CNT_SUB   = 9'h010;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_FETCH = 4'b0010,
		S_STALL = 4'b0100,
		S_LOAD  = 4'b1000
	} tlb_state_t;
endpackage : tlb_pkg

/* File: logic/tlb_irq.sv */
// Sticky interrupt status with mask and one level interrupt output.
// Assumes write strobes already qualified by the bus slave.
`timescale 1ns/100ps
module tlb_irq
	import tlb_pkg::*;
(
	input  wire logic            clk,       // System clock
	input  wire logic            rst,       // Synchronous reset
	input  wire logic [EV_W-1:0] events,    // One-cycle event pulses
	input  wire logic            statusWr,  // Write to status
	input  wire logic            maskWr,    // Write to mask
	input  wire logic [EV_W-1:0] wrData,    // Write data
	output logic      [EV_W-1:0] status_q,  // Sticky status
	output logic      [EV_W-1:0] mask_q,    // Enable mask
	output logic                 irq_q      // Level interrupt
);
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= '0;
		end else if (statusWr) begin
			// New event wins over the clear
			status_q <= (status_q & ~wrData) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q <= '0;
		end else if (maskWr) begin
			mask_q <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end
endmodule : tlb_irq

/* File: verification/tlb_mem_model.sv */
// Memory model holding handle tables, texture bases and look-up table words.
// Assumes the core's clock and word-aligned byte addresses below 1 KiB.
`timescale 1ns/100ps
module tlb_mem_model
	import tlb_pkg::*;
(
	input  wire logic              clk,          // System clock
	input  wire logic              rst,          // Synchronous reset
	input  wire logic [3:0]        slowWait,     // Stall cycles before each word
	input  wire logic              memRead,      // Read request
	input  wire logic [DATA_W-1:0] memAddr,      // Byte address
	output logic                   memWaitReq,   // Stall
	output logic      [DATA_W-1:0] memReadData   // Read data
);
	logic [DATA_W-1:0] words [0:255];
	logic [3:0]        waitCnt_q;
	logic [DATA_W-1:0] last_q;
	logic              ready;

	// One flat memory of 256 words, so byte addresses above 1 KiB wrap onto it
	assign ready       = memRead && (waitCnt_q >= slowWait);
	assign memWaitReq  = !ready;
	// Outside an answer the data bus shows the inverse of the previous cycle's word
	assign memReadData = ready ? words[memAddr[9:2]] : ~last_q;

	always_ff @(posedge clk) begin
		if (rst || !memRead || ready) begin
			waitCnt_q <= 4'h0;
		end else begin
			waitCnt_q <= waitCnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			last_q <= 32'h0000_0000;
		end else begin
			last_q <= memReadData;
		end
	end
endmodule : tlb_mem_model

/* File: verification/tlb_core_bench.sv */
// Self-checking bench for the texture look-up, handle and block-fill core.
// Assumes the memory model on the core's memory port and a 200 MHz clock.
`timescale 1ns/100ps
module tlb_core_bench;
	import tlb_pkg::*;

	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] tex;
		logic [7:0]  x;
		logic [7:0]  y;
		logic        msk;
		logic        stp;
		logic        wr;
		logic [31:0] col;
	} tlb_row_t;

	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [7:0]        address = 8'h00;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [DATA_W-1:0] writedata = 32'h0000_0000;
	logic              pixValid = 1'b0;
	logic [7:0]        pixX = 8'h00;
	logic [7:0]        pixY = 8'h00;
	logic [DATA_W-1:0] texel = 32'h0000_0000;
	logic              maskBit = 1'b0;
	logic              stippleBit = 1'b0;
	logic              lineStart = 1'b0;
	logic [3:0]        slowWait = 4'h0;
	logic [DATA_W-1:0] readdata, memAddr, memReadData, textureBase, pixColour;
	logic              waitrequest, irq, memRead, memWaitReq, pipeStall, pixWrite;
	logic [63:0]       fillColour;
	int                bad_count = 0;
	int                comparisons = 0;
	tlb_row_t          rows [8];

	always #2.5 clk = ~clk;

	tlb_core u_dut (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.irq, .memRead, .memAddr, .memWaitReq, .memReadData, .pipeStall, .textureBase,
		.pixValid, .pixX, .pixY, .texel, .maskBit, .stippleBit, .lineStart, .pixColour,
		.pixWrite, .fillColour);

	tlb_mem_model u_mem (.clk, .rst, .slowWait, .memRead, .memAddr, .memWaitReq, .memReadData);

	function automatic logic [31:0] lutVal(input logic [7:0] i);
		return {i + 8'h03, i + 8'h02, i + 8'h01, i};
	endfunction : lutVal

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// Holds the request until waitrequest is sampled low, then releases it
	task automatic busOp(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= !wr;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
		@(posedge clk);
	endtask : busOp

	task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		busOp(1'b1, a, d, q);
	endtask : busWrite

	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		busOp(1'b0, a, 32'h0000_0000, q);
		check(what, q, exp);
	endtask : rdChk

	// Waits for pipeStall (sel 0) or memRead (sel 1) to reach v
	task automatic waitHi(input int sel, input logic v);
		int n;
		n = 0;
		while (((sel == 0) ? pipeStall : memRead) !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (((sel == 0) ? pipeStall : memRead) !== v) begin
			bad_count++;
			$display("wrong value wait level expected %b seen %b", v, !v);
		end
	endtask : waitHi

	task automatic pixel(input tlb_row_t r);
		pixValid   <= 1'b1;
		texel      <= r.tex;
		pixX       <= r.x;
		pixY       <= r.y;
		maskBit    <= r.msk;
		stippleBit <= r.stp;
		@(posedge clk);
		pixValid <= 1'b0;
		@(posedge clk);
	endtask : pixel

	initial begin
		rows = '{
			'{32'h000, 32'h0000_00FF, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, lutVal(8'hFF)},
			'{32'h000, 32'h0000_0010, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, lutVal(8'h10)},
			'{32'h208, 32'h0000_00F7, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 32'hC0DE_0007},
			'{32'h002, 32'h5040_3010, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 32'h5342_3110},
			'{32'h004, 32'h0000_0000, 8'hA5, 8'hC3, 1'b1, 1'b1, 1'b1, lutVal(8'h35)},
			'{32'h040, 32'h0000_0010, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 32'h0000_0000},
			'{32'h040, 32'h0000_0010, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1, lutVal(8'h10)},
			'{32'h020, 32'h0000_0010, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000}
		};
		u_mem.words[8'h43] = 32'h8000_2000;
		u_mem.words[8'h44] = 32'h0000_3000;
		u_mem.words[8'h45] = 32'h8000_0200;
		for (int k = 0; k < 16; k++) u_mem.words[8'h80 + k] = 32'hC0DE_0000 + k;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		check("reset flags", {waitrequest, irq, memRead, pipeStall, pixWrite}, 5'b10000);
		check("reset base", textureBase, 32'h0000_0000);
		check("reset fill", fillColour, 64'h0);
		busWrite(REG_IRQ_MASK, 32'h0000_0003);
		rdChk("irq mask", REG_IRQ_MASK, 32'h0000_0003);
		busWrite(8'h3C, 32'hAAAA_5555);
		rdChk("unmapped", 8'h3C, 32'h0000_0000);
		busWrite(REG_FILL_LEG, 32'h5A5A_A5A5);
		check("legacy fill", fillColour, {2{32'h5A5A_A5A5}});
		rdChk("legacy read", REG_FILL_LEG, 32'h0000_0000);
		busWrite(REG_FILL_HI, 32'h1111_2222);
		busWrite(REG_FILL_LO, 32'h3333_4444);
		check("fill halves", fillColour, 64'h1111_2222_3333_4444);
		rdChk("fill high", REG_FILL_HI, 32'h1111_2222);
		busWrite(REG_DIR_BASE, 32'h0000_1000);
		rdChk("direct base", REG_TEX_BASE, 32'h0000_1000);
		// Slow memory while resolving a valid handle
		slowWait <= 4'h3;
		busWrite(REG_HND_TABLE, 32'h0000_0100);
		busWrite(REG_TEX_HND, 32'h0000_0003);
		waitHi(1, 1'b1);
		check("handle addr", memAddr, 32'h0000_010C);
		waitHi(0, 1'b0);
		check("resolved base", textureBase, 32'h0000_2000);
		// Invalid entry stalls until the host repairs it and restarts
		slowWait <= 4'h0;
		busWrite(REG_TEX_HND, 32'h0000_0004);
		waitHi(1, 1'b1);
		repeat (4) @(posedge clk);
		check("stall", {pipeStall, irq}, 2'b11);
		pixel('{32'h0, 32'h0, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 32'h0});
		check("gated pixel", pixWrite, 1'b0);
		rdChk("status invalid", REG_STATUS, 32'h0000_0001);
		u_mem.words[8'h44] = 32'h8000_3000;
		busWrite(REG_CTRL, 32'h0000_1000);
		waitHi(1, 1'b1);
		check("refetch addr", memAddr, 32'h0000_0110);
		waitHi(0, 1'b0);
		check("restart base", textureBase, 32'h0000_3000);
		busWrite(REG_STATUS, 32'h0000_0001);
		rdChk("status clear", REG_STATUS, 32'h0000_0000);
		check("irq clear", irq, 1'b0);
		// Full table over the bus, the index wraps after the last entry
		busWrite(REG_LUT_IDX, 32'h0000_0000);
		for (int i = 0; i < 256; i++) busWrite(REG_LUT_DATA, lutVal(8'(i)));
		busWrite(REG_LUT_IDX, 32'h0000_00FF);
		rdChk("lut last", REG_LUT_DATA, lutVal(8'hFF));
		rdChk("lut wrap", REG_LUT_IDX, 32'h0000_0000);
		// Sub-table 2 loaded from memory through a handle
		slowWait <= 4'h2;
		busWrite(REG_CTRL, 32'h0000_0201);
		busWrite(REG_LUT_HND, 32'h0000_0005);
		waitHi(1, 1'b1);
		check("lut handle addr", memAddr, 32'h0000_0114);
		waitHi(0, 1'b0);
		rdChk("status load", REG_STATUS, 32'h0000_0002);
		busWrite(REG_STATUS, 32'h0000_0002);
		for (int i = 0; i < 8; i++) begin
			busWrite(REG_CTRL, rows[i].ctrl);
			pixel(rows[i]);
			check("pixel write", pixWrite, rows[i].wr);
			if (rows[i].wr) check("pixel colour", pixColour, rows[i].col);
		end
		busWrite(REG_CTRL, 32'h0000_0010);
		pixY      <= 8'h07;
		lineStart <= 1'b1;
		@(posedge clk);
		lineStart <= 1'b0;
		@(posedge clk);
		check("pattern fill", fillColour, {lutVal(8'h07), lutVal(8'h07)});
		// Split mode alone, with a sub-table number above seven
		busWrite(REG_CTRL, 32'h0000_0A01);
		rdChk("ctrl read", REG_CTRL, 32'h0000_0A01);
		pixel('{32'h0, 32'h0000_0003, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 32'h0});
		check("split colour", pixColour, lutVal(8'hA3));
		// Reset again in mid-run
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check("mid reset flags", {waitrequest, irq, memRead, pipeStall, pixWrite}, 5'b10000);
		check("mid reset data", readdata, 32'h0000_0000);
		check("mid reset base", textureBase, 32'h0000_0000);
		check("mid reset fill", fillColour, 64'h0);
		rdChk("mid reset ctrl", REG_CTRL, 32'h0000_0000);
		rdChk("mid reset mask", REG_IRQ_MASK, 32'h0000_0000);
		conclude();
	end

	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule : tlb_core_bench
